/* design/ufd_core.sv */
// Serial port FIFO, interrupt identity, line status and DMA request signalling
// Function
// - Receive interrupt while count at or above threshold
// - Identity reports receive data, clears with interrupt
// - Data-ready set on push, clear when empty
// - All interrupt enables cleared gives polled mode
// - Line status bits report errors and empties
// - Mode 0 transmit request low when transmit queue empty
// - Mode 0 receive request low when character loaded
// - Mode 1 transmit interrupt when any space free
// - Mode 1 receive interrupt at threshold, keep filling
// - Mode 1 receive request low at or above threshold
// - Control bits 7:6 select receive threshold
// - Control bit 3 selects DMA mode, default 0
// - Mode 0 transmit request low only when empty
// - Mode 0 receive request low while data held
// - Mode 1 transmit request high only when full
// - Mode 1 receive request until FIFO emptied
// - Threshold codes give 1, 4, 8, 14 bytes
// - Control writes without enable bit clear the enable, keep mode and threshold
// - Receive time-out reported as code 1100
`timescale 1ns/1ps
module ufd_core #(
    parameter int DEPTH = 16
) (
    input  wire logic       core_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       cs_in,
    input  wire logic       rd_in,
    input  wire logic       wr_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    input  wire logic       rx_push_in,
    input  wire logic [7:0] rx_data_in,
    input  wire logic       rx_perr_in,
    input  wire logic       rx_ferr_in,
    input  wire logic       rx_brk_in,
    input  wire logic       rx_timeout_in,
    input  wire logic       tx_shift_ready_in,
    input  wire logic       tx_shift_empty_in,
    output logic            tx_load_out,
    output logic      [7:0] tx_data_out,
    output logic            int_out,
    output logic            tx_dma_request_n_out,
    output logic            rx_dma_request_n_out
);
    localparam int CW = $clog2(DEPTH+1);

    // Threshold of 14 and pointer wrap need a power-of-two depth of 16 or more
    if (DEPTH < 16 || (1 << $clog2(DEPTH)) != DEPTH) begin : g_chk
        $error("ufd_core: DEPTH must be a power of two, at least 16");
    end

    typedef struct packed {
        logic [3:0]          imask;
        logic                fifo_en;
        logic                dma_mode;
        logic [1:0]          trig_sel;
        logic [3:0]          line_err;   // break, framing, parity, overrun
        logic                fifo_err;
        logic                tmo;
        logic                thre_src;
        logic                thre_pend;
        ufd_pkg::ufd_rxreq_e rxreq;
        logic [7:0]        rdata;
        logic              tx_load;
        logic [7:0]        tx_data;
        logic              irq;
        logic              tx_req_n;
        logic              rx_req_n;
    } ufd_core_s;

    ufd_core_s q;
    ufd_core_s d;

    // Trigger level decode
    function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_level = CW'(ufd_pkg::TRIG_LVL0);
            2'h1: trig_level = CW'(ufd_pkg::TRIG_LVL1);
            2'h2: trig_level = CW'(ufd_pkg::TRIG_LVL2);
            2'h3: trig_level = CW'(ufd_pkg::TRIG_LVL3);
        endcase
    endfunction

    logic [10:0]   rx_head;
    logic [7:0]    tx_head;
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] limit;
    logic          rd_evt, wr_evt, fctl_wr, ident_rd, lstat_rd;
    logic          rx_full, tx_full, rx_trig, rx_pop, tx_push, tx_pop, rx_ok;
    logic          rx_clr, tx_clr, rx_level_int, tmo_int, line_int, thre_int, thre_rise;
    logic [3:0]    ident_code;
    logic [3:0]    new_err;

    ufd_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_fifo (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .clear_in    (rx_clr),
        .push_in     (rx_ok),
        .wdata_in    ({rx_brk_in, rx_ferr_in, rx_perr_in, rx_data_in}),
        .pop_in      (rx_pop),
        .rdata_out   (rx_head),
        .count_out   (rx_cnt)
    );

    ufd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .clear_in    (tx_clr),
        .push_in     (tx_push),
        .wdata_in    (wdata_in),
        .pop_in      (tx_pop),
        .rdata_out   (tx_head),
        .count_out   (tx_cnt)
    );

    always_comb begin
        rd_evt  = cs_in & rd_in;
        wr_evt  = cs_in & wr_in;
        fctl_wr  = wr_evt & (addr_in == ufd_pkg::ADDR_IDENT_CTRL);
        ident_rd = rd_evt & (addr_in == ufd_pkg::ADDR_IDENT_CTRL);
        lstat_rd = rd_evt & (addr_in == ufd_pkg::ADDR_LSTAT);
        // Without FIFOs each queue behaves as a single holding register
        limit   = q.fifo_en ? CW'(DEPTH) : CW'(1);
        rx_full = rx_cnt >= limit;
        tx_full = tx_cnt >= limit;
        rx_trig = q.fifo_en & (rx_cnt >= trig_level(q.trig_sel));
        rx_ok   = rx_push_in & ~rx_full;
        rx_pop  = rd_evt & (addr_in == ufd_pkg::ADDR_DATA) & (rx_cnt != '0);
        tx_push = wr_evt & (addr_in == ufd_pkg::ADDR_DATA) & ~tx_full;
        tx_pop  = tx_shift_ready_in & (tx_cnt != '0) & ~q.tx_load;
        // Changing the enable bit flushes both queues
        rx_clr  = fctl_wr & ((wdata_in[ufd_pkg::FCTL_EN_BIT] & wdata_in[ufd_pkg::FCTL_RXCLR_BIT])
                  | (wdata_in[ufd_pkg::FCTL_EN_BIT] != q.fifo_en));
        tx_clr  = fctl_wr & ((wdata_in[ufd_pkg::FCTL_EN_BIT] & wdata_in[ufd_pkg::FCTL_TXCLR_BIT])
                  | (wdata_in[ufd_pkg::FCTL_EN_BIT] != q.fifo_en));
        new_err = {rx_brk_in, rx_ferr_in, rx_perr_in, rx_push_in & rx_full} & {4{rx_push_in}};

        rx_level_int = q.imask[ufd_pkg::IMASK_RX_BIT]
                       & (q.fifo_en ? rx_trig : (rx_cnt != '0));
        tmo_int      = q.imask[ufd_pkg::IMASK_RX_BIT] & q.tmo;
        line_int     = q.imask[ufd_pkg::IMASK_LINE_BIT] & (|q.line_err);
        thre_int     = q.imask[ufd_pkg::IMASK_TXE_BIT] & q.thre_pend;

        if (line_int) begin
            ident_code = ufd_pkg::IDENT_LINE;
        end else if (rx_level_int) begin
            ident_code = ufd_pkg::IDENT_RXDATA;
        end else if (tmo_int) begin
            ident_code = ufd_pkg::IDENT_RXTMO;
        end else if (thre_int) begin
            ident_code = ufd_pkg::IDENT_TXE;
        end else begin
            ident_code = ufd_pkg::IDENT_NONE;
        end

        d = q;
        if (wr_evt && addr_in == ufd_pkg::ADDR_IMASK) begin
            d.imask = wdata_in[3:0];
        end
        // Bits 5:4 are not stored; software keeps them zero
        if (fctl_wr) begin
            d.fifo_en = wdata_in[ufd_pkg::FCTL_EN_BIT];
            if (wdata_in[ufd_pkg::FCTL_EN_BIT]) begin
                d.dma_mode = wdata_in[ufd_pkg::FCTL_DMA_BIT];
                d.trig_sel = wdata_in[ufd_pkg::FCTL_TRIG_MSB:ufd_pkg::FCTL_TRIG_LSB];
            end
        end

        // Error flags: a new error wins over the clearing read
        d.line_err = new_err | (q.line_err & {4{~lstat_rd}});
        d.fifo_err = (q.fifo_en & (|new_err[3:1])) | (q.fifo_err & ~lstat_rd);
        d.tmo      = (rx_timeout_in & q.fifo_en) | (q.tmo & ~rx_pop & ~rx_clr);

        // Transmit interrupt source: any free slot in block mode, else empty
        d.thre_src = (q.fifo_en & q.dma_mode) ? ~tx_full : (tx_cnt == '0);
        thre_rise  = d.thre_src & ~q.thre_src;
        d.thre_pend = d.thre_src
                      & (thre_rise | (q.thre_pend & ~(ident_rd & ident_code == ufd_pkg::IDENT_TXE)));

        unique case (q.rxreq)
            ufd_pkg::RXREQ_IDLE: begin
                if (rx_trig || q.tmo) begin
                    d.rxreq = ufd_pkg::RXREQ_ACTIVE;
                end
            end
            ufd_pkg::RXREQ_ACTIVE: begin
                if (rx_cnt == '0) begin
                    d.rxreq = ufd_pkg::RXREQ_IDLE;
                end
            end
        endcase

        if (q.fifo_en && q.dma_mode) begin
            d.tx_req_n = tx_full;
            d.rx_req_n = ~(rx_trig | q.tmo
                           | (q.rxreq == ufd_pkg::RXREQ_ACTIVE && rx_cnt != '0));
        end else begin
            d.tx_req_n = (tx_cnt != '0);
            d.rx_req_n = (rx_cnt == '0);
        end

        // Polled mode is simply every enable bit clear
        d.irq = line_int | rx_level_int | tmo_int | thre_int;

        d.tx_load = tx_pop;
        if (tx_pop) begin
            d.tx_data = tx_head;
        end

        if (rd_evt) begin
            unique case (addr_in)
                ufd_pkg::ADDR_DATA:    d.rdata = rx_head[7:0];
                ufd_pkg::ADDR_IMASK:      d.rdata = {4'h0, q.imask};
                ufd_pkg::ADDR_IDENT_CTRL: d.rdata = {q.fifo_en, q.fifo_en, 2'h0, ident_code};
                ufd_pkg::ADDR_LSTAT:      d.rdata = {q.fifo_err,
                                                  (tx_cnt == '0) & tx_shift_empty_in & ~q.tx_load,
                                                  (tx_cnt == '0),
                                                  q.line_err,
                                                  (rx_cnt != '0)};
                default:               d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q           <= '0;
            q.imask     <= ufd_pkg::IMASK_RST;
            q.fifo_en   <= ufd_pkg::FIFO_EN_RST;
            q.dma_mode  <= ufd_pkg::DMA_RST;
            q.trig_sel  <= ufd_pkg::TRIG_SEL_RST;
            q.rxreq     <= ufd_pkg::RXREQ_IDLE;
            q.rdata     <= ufd_pkg::RDATA_RST;
            q.tx_req_n  <= 1'b0;
            q.rx_req_n  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdata_out            = q.rdata;
    assign tx_load_out          = q.tx_load;
    assign tx_data_out          = q.tx_data;
    assign int_out              = q.irq;
    assign tx_dma_request_n_out = q.tx_req_n;
    assign rx_dma_request_n_out = q.rx_req_n;

    rx_int_level_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        q.fifo_en && q.imask[ufd_pkg::IMASK_RX_BIT] && rx_trig |=> int_out)
        else $error("receive interrupt missing at threshold");
    ident_rx_code_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        ident_rd && rx_level_int && !line_int |=> rdata_out[3:0] == 4'h4)
        else $error("identity does not report receive data");
    data_ready_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lstat_rd |=> rdata_out[0] == ($past(rx_cnt) != '0))
        else $error("data ready bit disagrees with receive count");
    polled_quiet_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        q.imask == 4'h0 |=> !int_out)
        else $error("interrupt raised with all enables clear");
    tx_req_mode0_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !(q.fifo_en && q.dma_mode) |=> tx_dma_request_n_out == ($past(tx_cnt) != '0))
        else $error("mode 0 transmit request wrong");
    tx_req_mode1_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        q.fifo_en && q.dma_mode |=> tx_dma_request_n_out == $past(tx_full))
        else $error("mode 1 transmit request wrong");
    rx_req_mode0_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !(q.fifo_en && q.dma_mode) && rx_cnt != '0 |=> !rx_dma_request_n_out)
        else $error("mode 0 receive request not asserted");
    rx_req_mode1_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        q.fifo_en && q.dma_mode && rx_trig |=> !rx_dma_request_n_out)
        else $error("mode 1 receive request not held above threshold");
    fcr_ignore_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fctl_wr && !wdata_in[0] |=> !q.fifo_en && $stable(q.dma_mode) && $stable(q.trig_sel))
        else $error("control bits taken without enable");
    trig_sel_wr_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fctl_wr && wdata_in[0] |=> q.trig_sel == $past(wdata_in[7:6])
            && q.dma_mode == $past(wdata_in[3]))
        else $error("threshold or mode select not stored");
    ident_tmo_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        ident_rd && tmo_int && !rx_level_int && !line_int |=> rdata_out[3:0] == 4'hC)
        else $error("time-out code not reported");
endmodule // ufd_core

/* design/ufd_pkg.sv */
// Constants shared by the FIFO signalling block: addresses, fields, codes and reset values
package ufd_pkg;
    // Register addresses on the three-bit parallel bus
    localparam logic [2:0] ADDR_DATA    = 3'h0;
    localparam logic [2:0] ADDR_IMASK      = 3'h1;
    localparam logic [2:0] ADDR_IDENT_CTRL = 3'h2;
    localparam logic [2:0] ADDR_LSTAT      = 3'h5;

    // fifo_control_reg fields
    localparam int FCTL_EN_BIT    = 0;
    localparam int FCTL_RXCLR_BIT = 1;
    localparam int FCTL_TXCLR_BIT = 2;
    localparam int FCTL_DMA_BIT   = 3;
    localparam int FCTL_TRIG_LSB  = 6;
    localparam int FCTL_TRIG_MSB  = 7;

    // interrupt_mask_reg fields
    localparam int IMASK_RX_BIT   = 0;
    localparam int IMASK_TXE_BIT  = 1;
    localparam int IMASK_LINE_BIT = 2;

    // Receive trigger levels in characters
    localparam logic [4:0] TRIG_LVL0 = 5'h01;
    localparam logic [4:0] TRIG_LVL1 = 5'h04;
    localparam logic [4:0] TRIG_LVL2 = 5'h08;
    localparam logic [4:0] TRIG_LVL3 = 5'h0E;

    // interrupt_ident_reg codes, bits 3:0
    localparam logic [3:0] IDENT_NONE   = 4'h1;
    localparam logic [3:0] IDENT_LINE   = 4'h6;
    localparam logic [3:0] IDENT_RXDATA = 4'h4;
    localparam logic [3:0] IDENT_RXTMO  = 4'hC;
    localparam logic [3:0] IDENT_TXE    = 4'h2;

    // Values after reset
    localparam logic [3:0] IMASK_RST    = 4'h0;
    localparam logic       FIFO_EN_RST  = 1'b0;
    localparam logic       DMA_RST      = 1'b0;
    localparam logic [1:0] TRIG_SEL_RST = 2'h0;
    localparam logic [7:0] RDATA_RST   = 8'h00;

    // Receive request state for block DMA mode
    typedef enum logic {
        RXREQ_IDLE   = 1'b0,
        RXREQ_ACTIVE = 1'b1
    } ufd_rxreq_e;
endpackage

/* design/ufd_fifo.sv */
// Flip-flop FIFO with synchronous clear, used for both receive and transmit queues
`timescale 1ns/1ps
module ufd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       core_clk_in,
    input  wire logic                       resetn_in,
    input  wire logic                       clear_in,
    input  wire logic                       push_in,
    input  wire logic [WIDTH-1:0]           wdata_in,
    input  wire logic                       pop_in,
    output logic      [WIDTH-1:0]           rdata_out,
    output logic      [$clog2(DEPTH+1)-1:0] count_out
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("ufd_fifo: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd_ptr;
        logic [AW-1:0]               wr_ptr;
        logic [AW:0]                 count;
    } ufd_fifo_s;

    ufd_fifo_s q;
    ufd_fifo_s d;

    // Caller guards push against full and pop against empty
    always_comb begin
        d = q;
        if (clear_in) begin
            d.rd_ptr = '0;
            d.wr_ptr = '0;
            d.count  = '0;
        end else begin
            if (push_in) begin
                d.mem[q.wr_ptr] = wdata_in;
                d.wr_ptr        = q.wr_ptr + AW'(1);
            end
            if (pop_in) begin
                d.rd_ptr = q.rd_ptr + AW'(1);
            end
            unique case ({push_in, pop_in})
                2'b10:   d.count = q.count + (AW+1)'(1);
                2'b01:   d.count = q.count - (AW+1)'(1);
                default: d.count = q.count;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata_out = q.mem[q.rd_ptr];
    assign count_out = q.count;
endmodule // ufd_fifo

/* tb/ufd_shifter_model.sv */
// Serial-side model: receive shifter that delivers characters, transmit shifter that takes them
`timescale 1ns/1ps
module ufd_shifter_model (
    input  wire logic       core_clk_in,
    input  wire logic       stall_in,
    input  wire logic       tx_load_in,
    input  wire logic [7:0] tx_data_in,
    output logic            rx_push_out,
    output logic      [7:0] rx_data_out,
    output logic            rx_perr_out,
    output logic            rx_ferr_out,
    output logic            rx_brk_out,
    output logic            rx_timeout_out,
    output logic            tx_shift_ready_out,
    output logic            tx_shift_empty_out
);
    logic [7:0] sent_q[$];
    int         busy;

    initial begin
        busy = 0;
        {rx_push_out, rx_perr_out, rx_ferr_out, rx_brk_out, rx_timeout_out} = 5'h00;
        rx_data_out = 8'h00;
        tx_shift_ready_out = 1'b0;
        tx_shift_empty_out = 1'b1;
    end

    // A loaded character keeps the shifter busy for a few cycles, like a short frame
    always @(posedge core_clk_in) begin
        if (tx_load_in) begin
            sent_q.push_back(tx_data_in);
            busy = 4;
        end else if (busy != 0) begin
            busy = busy - 1;
        end
    end

    always @(negedge core_clk_in) begin
        tx_shift_ready_out <= !stall_in && busy == 0;
        tx_shift_empty_out <= busy == 0;
    end

    // Data lines show the inverse once released so stale values never look valid
    task automatic push(input logic [7:0] d, input logic [2:0] f);
        @(negedge core_clk_in);
        rx_push_out = 1'b1;
        rx_data_out = d;
        {rx_brk_out, rx_ferr_out, rx_perr_out} = f;
        @(negedge core_clk_in);
        rx_push_out = 1'b0;
        rx_data_out = ~d;
        {rx_brk_out, rx_ferr_out, rx_perr_out} = 3'h0;
    endtask

    task automatic timeout_pulse();
        @(negedge core_clk_in);
        rx_timeout_out = 1'b1;
        @(negedge core_clk_in);
        rx_timeout_out = 1'b0;
    endtask
endmodule // ufd_shifter_model

/* tb/uart_fifo_irq_dma_signaling_tb.sv */
// Self-checking bench for the FIFO, interrupt and DMA request signalling block
`timescale 1ns/1ps
module uart_fifo_irq_dma_signaling_tb;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cs = 1'b0;
    logic       rd = 1'b0;
    logic       wr = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       stall = 1'b0;
    logic [7:0] rdata, rx_data, tx_data, v;
    logic       rx_push, perr, ferr, brk, tmo, tx_rdy, tx_emp, tx_load, irq, txreq_n, rxreq_n;
    int         bad_count = 0;
    int         n_checks = 0;
    int         lv[4] = '{1, 4, 8, 14};

    always #25 clk = ~clk;

    ufd_core i_ufd_core (.core_clk_in(clk), .resetn_in(rstn), .cs_in(cs), .rd_in(rd),
        .wr_in(wr), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
        .rx_push_in(rx_push), .rx_data_in(rx_data), .rx_perr_in(perr), .rx_ferr_in(ferr),
        .rx_brk_in(brk), .rx_timeout_in(tmo), .tx_shift_ready_in(tx_rdy),
        .tx_shift_empty_in(tx_emp), .tx_load_out(tx_load), .tx_data_out(tx_data),
        .int_out(irq), .tx_dma_request_n_out(txreq_n), .rx_dma_request_n_out(rxreq_n));

    ufd_shifter_model i_ufd_shifter_model (.core_clk_in(clk), .stall_in(stall),
        .tx_load_in(tx_load), .tx_data_in(tx_data), .rx_push_out(rx_push),
        .rx_data_out(rx_data), .rx_perr_out(perr), .rx_ferr_out(ferr), .rx_brk_out(brk),
        .rx_timeout_out(tmo), .tx_shift_ready_out(tx_rdy), .tx_shift_empty_out(tx_emp));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pins(input logic ei, input logic etx, input logic erx);
        chk("int", {7'h00, ei}, {7'h00, irq});
        chk("tx request", {7'h00, etx}, {7'h00, txreq_n});
        chk("rx request", {7'h00, erx}, {7'h00, rxreq_n});
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        {cs, wr, addr, wdata} = {2'b11, a, d};
        @(negedge clk);
        {cs, wr, wdata} = {2'b00, ~d};
        repeat (2) @(negedge clk);
    endtask

    // Read data is registered and holds, so it is taken two cycles after the strobe ends
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        {cs, rd, addr} = {2'b11, a};
        @(negedge clk);
        {cs, rd} = 2'b00;
        repeat (2) @(negedge clk);
        d = rdata;
    endtask

    task automatic push(input logic [7:0] d, input logic [2:0] f);
        i_ufd_shifter_model.push(d, f);
        repeat (3) @(negedge clk);
    endtask

    task automatic rd_chk(input logic [2:0] a, input string what, input logic [7:0] exp);
        rd_reg(a, v);
        chk(what, exp, v);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end

    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        pins(1'b0, 1'b0, 1'b1);
        rd_chk(ufd_pkg::ADDR_LSTAT, "status reset", 8'h60);
        rd_chk(3'h3, "unmapped", 8'h00);
        foreach (lv[i]) begin
            wr_reg(ufd_pkg::ADDR_IDENT_CTRL, {2'(i), 6'h03});
            wr_reg(ufd_pkg::ADDR_IMASK, 8'h01);
            for (int k = 1; k <= lv[i]; k++) begin
                rd_chk(ufd_pkg::ADDR_IDENT_CTRL, "ident below", 8'hC1);
                chk("int below", 8'h00, {7'h00, irq});
                push(8'(k), 3'h0);
            end
            rd_chk(ufd_pkg::ADDR_IDENT_CTRL, "ident level", 8'hC4);
            chk("int level", 8'h01, {7'h00, irq});
            rd_chk(ufd_pkg::ADDR_DATA, "head", 8'h01);
            rd_chk(ufd_pkg::ADDR_IDENT_CTRL, "ident drop", 8'hC1);
            chk("int drop", 8'h00, {7'h00, irq});
        end
        // Polled mode 0: all interrupt enables off
        wr_reg(ufd_pkg::ADDR_IDENT_CTRL, 8'h07);
        wr_reg(ufd_pkg::ADDR_IMASK, 8'h00);
        push(8'hA5, 3'h0);
        pins(1'b0, 1'b0, 1'b0);
        push(8'h5A, 3'h0);
        rd_chk(ufd_pkg::ADDR_LSTAT, "status ready", 8'h61);
        rd_chk(ufd_pkg::ADDR_DATA, "data 1", 8'hA5);
        rd_chk(ufd_pkg::ADDR_LSTAT, "status one left", 8'h61);
        chk("rx request one", 8'h00, {7'h00, rxreq_n});
        rd_chk(ufd_pkg::ADDR_DATA, "data 2", 8'h5A);
        rd_chk(ufd_pkg::ADDR_LSTAT, "status emptied", 8'h60);
        chk("rx request empty", 8'h01, {7'h00, rxreq_n});
        stall = 1'b1;
        wr_reg(ufd_pkg::ADDR_DATA, 8'h3C);
        chk("tx request loaded", 8'h01, {7'h00, txreq_n});
        rd_chk(ufd_pkg::ADDR_LSTAT, "status tx held", 8'h00);
        stall = 1'b0;
        repeat (12) @(negedge clk);
        chk("tx request sent", 8'h00, {7'h00, txreq_n});
        chk("tx byte", 8'h3C, i_ufd_shifter_model.sent_q[0]);
        rd_chk(ufd_pkg::ADDR_LSTAT, "status tx idle", 8'h60);
        for (int e = 0; e < 3; e++) begin
            push(8'h11, 3'(1 << e));
            rd_chk(ufd_pkg::ADDR_LSTAT, "status error", 8'hE1 | (8'h04 << e));
            rd_chk(ufd_pkg::ADDR_LSTAT, "status cleared", 8'h61);
            rd_chk(ufd_pkg::ADDR_DATA, "error data", 8'h11);
        end
        for (int k = 0; k < 17; k++) push(8'(k), 3'h0);
        rd_reg(ufd_pkg::ADDR_LSTAT, v);
        chk("status overrun", 8'h63, v & 8'h7F);
        // Block DMA mode, threshold 8
        wr_reg(ufd_pkg::ADDR_IDENT_CTRL, 8'h8F);
        for (int k = 1; k <= 7; k++) push(8'(k), 3'h0);
        chk("rx request under", 8'h01, {7'h00, rxreq_n});
        push(8'h08, 3'h0);
        chk("rx request level", 8'h00, {7'h00, rxreq_n});
        push(8'h09, 3'h0);
        push(8'h0A, 3'h0);
        for (int k = 1; k <= 10; k++) begin
            chk("rx request held", 8'h00, {7'h00, rxreq_n});
            rd_chk(ufd_pkg::ADDR_DATA, "block data", 8'(k));
        end
        chk("rx request done", 8'h01, {7'h00, rxreq_n});
        stall = 1'b1;
        i_ufd_shifter_model.sent_q.delete();
        for (int k = 0; k < 15; k++) wr_reg(ufd_pkg::ADDR_DATA, 8'(k));
        chk("tx request room", 8'h00, {7'h00, txreq_n});
        wr_reg(ufd_pkg::ADDR_DATA, 8'h0F);
        wr_reg(ufd_pkg::ADDR_DATA, 8'hEE);
        chk("tx request full", 8'h01, {7'h00, txreq_n});
        wr_reg(ufd_pkg::ADDR_IMASK, 8'h02);
        chk("int full", 8'h00, {7'h00, irq});
        stall = 1'b0;
        repeat (5) @(negedge clk);
        chk("int space", 8'h01, {7'h00, irq});
        rd_chk(ufd_pkg::ADDR_IDENT_CTRL, "ident tx", 8'hC2);
        chk("int read", 8'h00, {7'h00, irq});
        repeat (150) @(negedge clk);
        chk("tx sent count", 8'h10, 8'(i_ufd_shifter_model.sent_q.size()));
        for (int k = 0; k < 16; k++) chk("tx order", 8'(k), i_ufd_shifter_model.sent_q[k]);
        // Time-out below threshold 4
        wr_reg(ufd_pkg::ADDR_IMASK, 8'h01);
        wr_reg(ufd_pkg::ADDR_IDENT_CTRL, 8'h4B);
        push(8'h77, 3'h0);
        pins(1'b0, 1'b0, 1'b1);
        i_ufd_shifter_model.timeout_pulse();
        repeat (3) @(negedge clk);
        pins(1'b1, 1'b0, 1'b0);
        rd_chk(ufd_pkg::ADDR_IDENT_CTRL, "ident timeout", 8'hCC);
        rd_chk(ufd_pkg::ADDR_DATA, "timeout data", 8'h77);
        pins(1'b0, 1'b0, 1'b1);
        // Control write without enable leaves the other bits unprogrammed
        wr_reg(ufd_pkg::ADDR_IDENT_CTRL, 8'hC8);
        rd_chk(ufd_pkg::ADDR_IDENT_CTRL, "ident legacy", 8'h01);
        push(8'h21, 3'h0);
        push(8'h22, 3'h0);
        chk("rx request legacy", 8'h00, {7'h00, rxreq_n});
        rd_reg(ufd_pkg::ADDR_LSTAT, v);
        chk("status legacy", 8'h63, v & 8'h7F);
        rd_chk(ufd_pkg::ADDR_DATA, "legacy data", 8'h21);
        chk("rx request legacy empty", 8'h01, {7'h00, rxreq_n});
        conclude();
    end
endmodule // uart_fifo_irq_dma_signaling_tb
